// ### rtl/ebh_bridge.sv
`timescale 1ns/1ns
module ebh_bridge
  import ebh_pkg::*;
#(
  parameter int SETUP_CYC = EBH_SETUP_CYC,
  parameter int STROBE_CYC = EBH_STROBE_CYC,
  parameter int HOLD_CYC = EBH_HOLD_CYC
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic tgt_reset_n,
  output logic [3:0] tgt_mode_strap,
  output logic [7:0] tgt_addr,
  output logic [15:0] tgt_data_out,
  output logic tgt_data_oe,
  input wire logic [15:0] tgt_data_in,
  output logic tgt_cs_n,
  output logic tgt_strobe_n,
  output logic tgt_rw_wr_n,
  output logic tgt_ale,
  output logic comp_reset_n,
  output logic comp_pcm_clk,
  output logic comp_cfi_clk,
  output logic comp_pcm_fsync,
  output logic iom_dcl_out,
  output logic iom_dcl_oe,
  input wire logic iom_dcl_in,
  output logic iom_fsc_out,
  output logic iom_fsc_oe,
  input wire logic iom_fsc_in,
  input wire logic comp_dd,
  input wire logic ext_dd,
  output logic tgt_dd
);

  // ------------------------------------------------------------
  // Parameter checks
  // ------------------------------------------------------------
  if (SETUP_CYC < 1 || SETUP_CYC > 15 || STROBE_CYC < 1 || STROBE_CYC > 15 ||
      HOLD_CYC < 1 || HOLD_CYC > 15) begin : g_bad_timing
    $error("ebh_bridge: phase counts must lie in 1..15");
  end

  localparam logic [3:0] SETUP_LD = 4'(SETUP_CYC - 1);
  localparam logic [3:0] STROBE_LD = 4'(STROBE_CYC - 1);
  localparam logic [3:0] HOLD_LD = 4'(HOLD_CYC - 1);

  // ------------------------------------------------------------
  // Control registers and mode decode
  // ------------------------------------------------------------
  logic [7:0] board_ctrl_reg_first, next_first;
  logic [7:0] board_ctrl_reg_second, next_second;
  logic [7:0] board_ctrl_reg_third, next_third;
  logic [3:0] target_mode_field;
  logic is_iom, fwd_ok, narrow, sep, mux, comp_bit, ext_bit;

  // Mode field steers the whole target port
  assign target_mode_field = board_ctrl_reg_second[3:0];
  assign is_iom = target_mode_field == EBH_MODE_IOM;
  // Codes above the last emulated style, serial one included, stay local
  assign fwd_ok = target_mode_field <= EBH_MODE_MUX8;
  assign narrow = target_mode_field[0];  // Odd codes are 8-bit
  assign sep = target_mode_field >= EBH_MODE_DMX16;
  assign mux = target_mode_field >= EBH_MODE_MUX16;
  assign comp_bit = board_ctrl_reg_first[EBH_BIT_COMP_RST];
  // Master choice is ignored outside serial mode
  assign ext_bit = board_ctrl_reg_first[EBH_BIT_EXT_MASTER] && is_iom;

  // ------------------------------------------------------------
  // Bus slave and target access sequencer
  // ------------------------------------------------------------
  ebh_acc_state_t st, next_st;
  logic [3:0] cnt, next_cnt;
  logic acc_wr, next_acc_wr;
  logic wr_pend, next_wr_pend;
  logic [11:0] wr_ofs, next_wr_ofs;
  logic next_hreadyout;
  logic [31:0] next_hrdata;
  logic [7:0] next_tgt_addr;
  logic [15:0] next_tgt_data_out;
  logic next_tgt_data_oe, next_tgt_cs_n, next_tgt_strobe_n;
  logic next_tgt_rw_wr_n, next_tgt_ale;
  logic addr_ph, tgt_hit, strobing;

  assign addr_ph = hsel && htrans[1] && hready;
  assign tgt_hit = haddr[11:10] == EBH_TGT_WIN;

  // Register writes land in the data phase; reads see that same cycle's write
  always_comb begin
    next_first = board_ctrl_reg_first;
    next_second = board_ctrl_reg_second;
    next_third = board_ctrl_reg_third;
    next_st = st;
    next_cnt = cnt;
    next_acc_wr = acc_wr;
    next_wr_pend = 1'b0;
    next_wr_ofs = wr_ofs;
    next_hreadyout = hreadyout;
    next_hrdata = hrdata;
    next_tgt_addr = tgt_addr;
    next_tgt_data_out = tgt_data_out;
    next_tgt_data_oe = tgt_data_oe;
    next_tgt_cs_n = tgt_cs_n;
    next_tgt_ale = 1'b0;
    strobing = 1'b0;
    if (wr_pend) begin
      case (wr_ofs)
        EBH_OFS_FIRST: next_first = hwdata[7:0];
        EBH_OFS_SECOND: next_second = hwdata[7:0];
        EBH_OFS_THIRD: next_third = hwdata[7:0];
        default: next_first = board_ctrl_reg_first;
      endcase
    end
    case (st)
      ST_IDLE: begin
        if (addr_ph && tgt_hit && fwd_ok) begin
          next_st = ST_LATCH;
          next_hreadyout = 1'b0;
          next_acc_wr = hwrite;
          // One extra shift for byte access; A1 lands on A0 in 16-bit modes, A2 in byte modes
          next_tgt_addr = narrow ? haddr[9:2] : haddr[8:1];
          next_tgt_ale = mux;
          next_tgt_data_out = mux ? {8'h00, next_tgt_addr} : 16'h0000;
          next_tgt_data_oe = mux;
        end else if (addr_ph && tgt_hit) begin
          next_hrdata = 32'h0000_0000;  // Not forwarded
        end else if (addr_ph) begin
          next_wr_pend = hwrite;
          next_wr_ofs = haddr[11:0];
          // Eight meaningful bits per control register, three in status, rest reads zero
          case (haddr[11:0])
            EBH_OFS_FIRST: next_hrdata = {24'h00_0000, next_first};
            EBH_OFS_SECOND: next_hrdata = {24'h00_0000, next_second};
            EBH_OFS_THIRD: next_hrdata = {24'h00_0000, next_third};
            EBH_OFS_STATUS: next_hrdata = {28'h000_0000, !fwd_ok, iom_dcl_oe,
                                           comp_reset_n, 1'b0};
            default: next_hrdata = 32'h0000_0000;
          endcase
        end
      end
      ST_LATCH: begin
        // Write data is valid now; width follows the mode field
        next_st = ST_SETUP;
        next_cnt = SETUP_LD;
        next_tgt_cs_n = 1'b0;
        next_tgt_data_out = narrow ? {8'h00, hwdata[7:0]} : hwdata[15:0];
        next_tgt_data_oe = acc_wr;
      end
      ST_SETUP: begin
        if (cnt == 4'h0) begin
          next_st = ST_STROBE;
          next_cnt = STROBE_LD;
          strobing = 1'b1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      ST_STROBE: begin
        if (cnt == 4'h0) begin
          next_st = ST_HOLD;
          next_cnt = HOLD_LD;
          next_hrdata = {16'h0000, narrow ? {8'h00, tgt_data_in[7:0]} : tgt_data_in};
        end else begin
          next_cnt = cnt - 4'h1;
          strobing = 1'b1;
        end
      end
      ST_HOLD: begin
        if (cnt == 4'h0) begin
          next_st = ST_IDLE;
          next_tgt_cs_n = 1'b1;
          next_tgt_data_oe = 1'b0;
          next_hreadyout = 1'b1;
        end else begin
          next_cnt = cnt - 4'h1;
        end
      end
      default: next_st = ST_IDLE;
    endcase
    // Bus style pins: data strobe plus direction, or read and write strobes
    next_tgt_strobe_n = !(strobing && !(sep && acc_wr));
    next_tgt_rw_wr_n = (sep && !strobing) ? 1'b1 : !next_acc_wr;
  end

  // Everything toward the target leaves from a flop, so byte mode is buffered
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      board_ctrl_reg_first <= EBH_RST_FIRST;
      board_ctrl_reg_second <= EBH_RST_SECOND;  // Default style and width
      board_ctrl_reg_third <= EBH_RST_THIRD;
      st <= ST_IDLE;
      cnt <= 4'h0;
      acc_wr <= 1'b0;
      wr_pend <= 1'b0;
      wr_ofs <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
      tgt_reset_n <= 1'b0;
      tgt_mode_strap <= 4'h0;
      tgt_addr <= 8'h00;
      tgt_data_out <= 16'h0000;
      tgt_data_oe <= 1'b0;
      tgt_cs_n <= 1'b1;
      tgt_strobe_n <= 1'b1;
      tgt_rw_wr_n <= 1'b1;
      tgt_ale <= 1'b0;
    end else begin
      board_ctrl_reg_first <= next_first;
      board_ctrl_reg_second <= next_second;
      board_ctrl_reg_third <= next_third;
      st <= next_st;
      cnt <= next_cnt;
      acc_wr <= next_acc_wr;
      wr_pend <= next_wr_pend;
      wr_ofs <= next_wr_ofs;
      hreadyout <= next_hreadyout;
      hresp <= 1'b0;
      hrdata <= next_hrdata;
      // Strap changes are only safe while the target sits in reset
      tgt_reset_n <= next_first[EBH_BIT_TGT_RST];
      tgt_mode_strap <= next_second[3:0];
      tgt_addr <= next_tgt_addr;
      tgt_data_out <= next_tgt_data_out;
      tgt_data_oe <= next_tgt_data_oe;
      tgt_cs_n <= next_tgt_cs_n;
      tgt_strobe_n <= next_tgt_strobe_n;
      tgt_rw_wr_n <= next_tgt_rw_wr_n;
      tgt_ale <= next_tgt_ale;
    end
  end

  // ------------------------------------------------------------
  // Serial clock generator and companion control
  // ------------------------------------------------------------
  logic iom_run;
  logic [5:0] div_cnt, next_div_cnt, half;
  logic [9:0] frm_cnt, next_frm_cnt, frame;
  logic next_dcl, next_fsc;

  // Companion out of reset and clocked only as on-board master
  assign iom_run = is_iom && comp_bit && !ext_bit;

  // Ratio table from the third register; all counts run off mclk
  always_comb begin
    case (board_ctrl_reg_third[1:0])
      EBH_CLK_2M048: half = EBH_HALF_2M048;
      EBH_CLK_1M536: half = EBH_HALF_1M536;
      default: half = EBH_HALF_4M096;
    endcase
    case (board_ctrl_reg_third[1:0])
      EBH_CLK_2M048: frame = EBH_FRAME_2M048;
      EBH_CLK_1M536: frame = EBH_FRAME_1M536;
      default: frame = EBH_FRAME_4M096;
    endcase
  end

  // Frame sync is one bit clock wide, counted on falling bit clock edges
  always_comb begin
    next_div_cnt = div_cnt;
    next_frm_cnt = frm_cnt;
    next_dcl = iom_dcl_out;
    next_fsc = iom_fsc_out;
    if (!iom_run) begin
      next_div_cnt = 6'h00;
      next_frm_cnt = 10'h000;
      next_dcl = 1'b0;
      next_fsc = 1'b0;
    end else if (div_cnt >= half - 6'h01) begin
      next_div_cnt = 6'h00;
      next_dcl = !iom_dcl_out;
      if (iom_dcl_out) begin
        next_frm_cnt = (frm_cnt >= frame - 10'h001) ? 10'h000 : frm_cnt + 10'h001;
        next_fsc = next_frm_cnt == 10'h000;
      end
    end else begin
      next_div_cnt = div_cnt + 6'h01;
    end
  end

  // Pins released while an external master owns the clocks
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt <= 6'h00;
      frm_cnt <= 10'h000;
      iom_dcl_out <= 1'b0;
      iom_fsc_out <= 1'b0;
      iom_dcl_oe <= 1'b0;
      iom_fsc_oe <= 1'b0;
      comp_reset_n <= 1'b0;
      comp_pcm_clk <= 1'b0;
      comp_cfi_clk <= 1'b0;
      comp_pcm_fsync <= 1'b0;
      tgt_dd <= 1'b0;
    end else begin
      div_cnt <= next_div_cnt;
      frm_cnt <= next_frm_cnt;
      iom_dcl_out <= next_dcl;
      iom_fsc_out <= next_fsc;
      iom_dcl_oe <= iom_run;
      iom_fsc_oe <= iom_run;
      comp_reset_n <= iom_run;
      comp_pcm_clk <= next_dcl;  // Same source for both clocks
      comp_cfi_clk <= next_dcl;
      comp_pcm_fsync <= next_fsc;
      tgt_dd <= ext_bit ? ext_dd : comp_dd;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  logic reg_rd_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rd_q <= 1'b0;
    end else begin
      reg_rd_q <= addr_ph && !tgt_hit && !hwrite && st == ST_IDLE;
    end
  end

  sequence s_start;
    addr_ph && st == ST_IDLE && tgt_hit && fwd_ok;
  endsequence
  // Separate style writes pulse the write strobe; both strobes must end together
  sequence s_strobe_pulse;
    (!tgt_strobe_n || !tgt_rw_wr_n && sep) [*6] ##1 (tgt_strobe_n && (tgt_rw_wr_n || !sep));
  endsequence

  chk_strap_from_reg: assert property (wr_pend && wr_ofs == EBH_OFS_SECOND |=>
    tgt_mode_strap == $past(hwdata[3:0])) else $error("strap not from register");
  chk_iom_no_fwd: assert property (addr_ph && tgt_hit && is_iom |=>
    st == ST_IDLE && hreadyout) else $error("access forwarded in serial mode");
  chk_narrow_shift: assert property (s_start and narrow |=>
    tgt_addr == $past(haddr[9:2])) else $error("byte address not shifted");
  chk_wide_a1_a0: assert property (s_start and !narrow |=>
    tgt_addr == $past(haddr[8:1])) else $error("A1 not on target A0");
  chk_strobe_len: assert property (($fell(tgt_strobe_n) || sep && $fell(tgt_rw_wr_n)) &&
    STROBE_CYC == 6 |-> s_strobe_pulse) else $error("strobe width wrong");
  chk_access_ends: assert property (s_start |-> ##[12:12] hreadyout && tgt_cs_n)
    else $error("access length wrong");
  chk_ext_holds_rst: assert property (ext_bit |=> !comp_reset_n && !iom_dcl_oe)
    else $error("companion not in reset");
  chk_clk_gated: assert property (!comp_bit |=> !comp_pcm_clk && !iom_fsc_oe)
    else $error("companion clock while reset bit low");
  chk_reg_8bit: assert property (reg_rd_q |-> hrdata[31:8] == 24'h00_0000)
    else $error("register read wider than 8 bits");
  chk_pcm_cfi_same: assert property (iom_run |=>
    comp_pcm_clk == comp_cfi_clk && comp_pcm_fsync == iom_fsc_out)
    else $error("companion clocks differ");

endmodule

// ### rtl/ebh_pkg.sv
package ebh_pkg;
  // ------------------------------------------------------------
  // Register map (byte offsets, own registers are 8 bits wide)
  // ------------------------------------------------------------
  localparam logic [11:0] EBH_OFS_FIRST = 12'h000;
  localparam logic [11:0] EBH_OFS_SECOND = 12'h004;
  localparam logic [11:0] EBH_OFS_THIRD = 12'h008;
  localparam logic [11:0] EBH_OFS_STATUS = 12'h00c;
  // haddr[11:10] selecting the forwarded target window
  localparam logic [1:0] EBH_TGT_WIN = 2'h1;
  localparam int EBH_BIT_TGT_RST = 0;
  localparam int EBH_BIT_COMP_RST = 1;
  localparam int EBH_BIT_EXT_MASTER = 2;
  localparam logic [7:0] EBH_RST_FIRST = 8'h00;
  localparam logic [7:0] EBH_RST_SECOND = 8'h00;
  localparam logic [7:0] EBH_RST_THIRD = 8'h00;
  // ------------------------------------------------------------
  // Target mode field codes
  // ------------------------------------------------------------
  localparam logic [3:0] EBH_MODE_RWS16 = 4'h0;
  localparam logic [3:0] EBH_MODE_RWS8 = 4'h1;
  localparam logic [3:0] EBH_MODE_DMX16 = 4'h2;
  localparam logic [3:0] EBH_MODE_DMX8 = 4'h3;
  localparam logic [3:0] EBH_MODE_MUX16 = 4'h4;
  localparam logic [3:0] EBH_MODE_MUX8 = 4'h5;
  localparam logic [3:0] EBH_MODE_IOM = 4'hf;
  // ------------------------------------------------------------
  // Access timing toward the target
  // ------------------------------------------------------------
  localparam int EBH_CLK_NS = 10;
  localparam int EBH_SETUP_NS = 20;
  localparam int EBH_STROBE_NS = 60;
  localparam int EBH_HOLD_NS = 20;
  localparam int EBH_SETUP_CYC = (EBH_SETUP_NS + EBH_CLK_NS - 1) / EBH_CLK_NS;
  localparam int EBH_STROBE_CYC = (EBH_STROBE_NS + EBH_CLK_NS - 1) / EBH_CLK_NS;
  localparam int EBH_HOLD_CYC = (EBH_HOLD_NS + EBH_CLK_NS - 1) / EBH_CLK_NS;
  // ------------------------------------------------------------
  // Serial clock field codes, half periods and frame lengths
  // ------------------------------------------------------------
  localparam logic [1:0] EBH_CLK_2M048 = 2'h0;
  localparam logic [1:0] EBH_CLK_1M536 = 2'h1;
  localparam logic [5:0] EBH_HALF_2M048 = 6'h18;
  localparam logic [5:0] EBH_HALF_1M536 = 6'h21;
  localparam logic [5:0] EBH_HALF_4M096 = 6'h0c;
  localparam logic [9:0] EBH_FRAME_2M048 = 10'h100;
  localparam logic [9:0] EBH_FRAME_1M536 = 10'h0c0;
  localparam logic [9:0] EBH_FRAME_4M096 = 10'h200;
  typedef enum {ST_IDLE, ST_LATCH, ST_SETUP, ST_STROBE, ST_HOLD} ebh_acc_state_t;
endpackage

// ### testbench/ebh_far_side.sv
`timescale 1ns/1ns
module ebh_far_side
  import ebh_pkg::*;
(
  input wire logic mclk,
  input wire logic [3:0] tgt_mode_strap,
  input wire logic [7:0] tgt_addr,
  input wire logic [15:0] tgt_data_out,
  input wire logic tgt_data_oe,
  output logic [15:0] tgt_data_in,
  input wire logic tgt_cs_n,
  input wire logic tgt_strobe_n,
  input wire logic tgt_rw_wr_n,
  input wire logic tgt_ale,
  input wire logic ext_on,
  input wire logic iom_dcl_out,
  input wire logic iom_dcl_oe,
  output logic iom_dcl_in,
  input wire logic iom_fsc_out,
  input wire logic iom_fsc_oe,
  output logic iom_fsc_in
);
  logic [15:0] mem [256];
  logic [15:0] last_d;
  logic [7:0] mux_addr, a;
  logic sep, mux, wr_act, rd_act, ext_dcl, idle_tgl;
  int n_div;
  int n_bit;
  // ----------------------------------------
  // Target parallel port
  // ----------------------------------------
  // Codes 2..5 use separate read and write strobes
  assign sep = tgt_mode_strap inside {[EBH_MODE_DMX16:EBH_MODE_MUX8]};
  assign mux = tgt_mode_strap inside {EBH_MODE_MUX16, EBH_MODE_MUX8};
  assign a = mux ? mux_addr : tgt_addr;
  assign wr_act = !tgt_cs_n && (sep ? !tgt_rw_wr_n : !tgt_strobe_n && !tgt_rw_wr_n);
  assign rd_act = !tgt_cs_n && !tgt_strobe_n && (sep || tgt_rw_wr_n);
  // Released bus shows the inverse of its last level, so stale data never matches
  assign tgt_data_in = rd_act ? mem[a] : ~last_d;
  always @(posedge mclk) begin
    last_d <= tgt_data_in;
    if (tgt_ale) mux_addr <= tgt_data_out[7:0];
    if (wr_act && tgt_data_oe) mem[a] <= tgt_data_out;
  end
  // ----------------------------------------
  // External serial master
  // ----------------------------------------
  // Free running bit clock, half period 12 mclk, frame mark every 16 bits
  always @(posedge mclk) begin
    idle_tgl <= !idle_tgl;
    n_div <= (n_div == 11) ? 0 : n_div + 1;
    if (n_div == 11) begin
      ext_dcl <= !ext_dcl;
      if (ext_dcl) n_bit <= (n_bit + 1) % 16;
    end
  end
  // Wire level from both drivers; undriven lines wander
  assign iom_dcl_in = iom_dcl_oe ? iom_dcl_out : ext_on ? ext_dcl : idle_tgl;
  assign iom_fsc_in = iom_fsc_oe ? iom_fsc_out : ext_on ? n_bit == 0 : idle_tgl;
  initial begin
    last_d = 16'h0000;
    idle_tgl = 1'b0;
    ext_dcl = 1'b0;
    n_div = 0;
    n_bit = 0;
  end
endmodule

// ### testbench/eval_board_host_mode_bridge_tb_top.sv
`timescale 1ns/1ns
module eval_board_host_mode_bridge_tb_top
  import ebh_pkg::*;
;
  logic mclk, reset_n, hsel, hwrite, hready, hreadyout, hresp, tgt_reset_n, tgt_data_oe;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tgt_mode_strap;
  logic [7:0] tgt_addr, seen_addr;
  logic [15:0] tgt_data_out, tgt_data_in;
  logic tgt_cs_n, tgt_strobe_n, tgt_rw_wr_n, tgt_ale, comp_reset_n, comp_pcm_clk, comp_cfi_clk;
  logic comp_pcm_fsync, iom_dcl_out, iom_dcl_oe, iom_dcl_in, iom_fsc_out, iom_fsc_oe, iom_fsc_in;
  logic comp_dd, ext_dd, tgt_dd, ext_on;
  int n_errors, comparisons, n_wait, n_ale, n_stb, n_cs, n_diff;
  assign hready = hreadyout;
  ebh_bridge uut (.mclk, .reset_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hreadyout, .hresp, .hrdata, .tgt_reset_n, .tgt_mode_strap, .tgt_addr, .tgt_data_out,
    .tgt_data_oe, .tgt_data_in, .tgt_cs_n, .tgt_strobe_n, .tgt_rw_wr_n, .tgt_ale, .comp_reset_n,
    .comp_pcm_clk, .comp_cfi_clk, .comp_pcm_fsync, .iom_dcl_out, .iom_dcl_oe, .iom_dcl_in,
    .iom_fsc_out, .iom_fsc_oe, .iom_fsc_in, .comp_dd, .ext_dd, .tgt_dd);
  ebh_far_side far (.mclk, .tgt_mode_strap, .tgt_addr, .tgt_data_out, .tgt_data_oe,
    .tgt_data_in, .tgt_cs_n, .tgt_strobe_n, .tgt_rw_wr_n, .tgt_ale, .ext_on, .iom_dcl_out,
    .iom_dcl_oe, .iom_dcl_in, .iom_fsc_out, .iom_fsc_oe, .iom_fsc_in);
  // ----------------------------------------
  // Clock, monitor and shared tasks
  // ----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  // Counts per access; the bench clears them before each access that it checks
  always @(posedge mclk) begin
    if (!hreadyout) n_wait++;
    if (tgt_ale) n_ale++;
    if (!tgt_strobe_n) n_stb++;
    if (comp_pcm_clk !== comp_cfi_clk) n_diff++;
    if (!tgt_cs_n) begin
      n_cs++;
      seen_addr = tgt_addr;
    end
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Single word transfer; no wait count assumed, only the watchdog ends a hang
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= wr;
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask
  task automatic rdc(input string w, input logic [31:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(1'b0, a, 32'h0, r);
    check(w, r, e);
    check("hresp", 32'(hresp), 32'h0);
  endtask
  task automatic settle;
    repeat (3) @(posedge mclk);
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    @(posedge mclk);
  endtask
  // Mode change only while the target is held in reset
  task automatic set_mode(input logic [3:0] m);
    wr(32'(EBH_OFS_FIRST), 32'h0);
    wr(32'(EBH_OFS_SECOND), 32'(m));
    wr(32'(EBH_OFS_FIRST), 32'h1);
    @(posedge mclk); // Released target reset shows one edge later
  endtask
  // Edges between two bit clock transitions
  task automatic half(output int n);
    logic p;
    p = iom_dcl_out;
    for (int i = 0; i < 300 && iom_dcl_out === p; i++) @(posedge mclk);
    p = iom_dcl_out;
    n = 0;
    while (n < 300 && iom_dcl_out === p) begin
      @(posedge mclk);
      n++;
    end
  endtask
  // Edges from one frame sync rise to the next
  task automatic frame_len(output int n);
    for (int i = 0; i < 13000 && iom_fsc_out !== 1'b1; i++) @(posedge mclk);
    n = 0;
    while (n < 13000 && iom_fsc_out === 1'b1) begin
      @(posedge mclk);
      n++;
    end
    while (n < 13000 && iom_fsc_out !== 1'b1) begin
      @(posedge mclk);
      n++;
    end
  endtask
  task automatic tally_and_finish;
    if (n_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Whole run is about twenty-five thousand cycles, mostly the frame wait
  initial begin
    #800000;
    n_errors++;
    tally_and_finish();
  end
  // ----------------------------------------
  // Test sequence
  // ----------------------------------------
  initial begin
    logic [3:0] md;
    logic [15:0] d;
    logic [7:0] ea;
    logic [3:0] nf [2];
    int he [3];
    int h;
    nf = '{4'h6, EBH_MODE_IOM};
    he = '{int'(EBH_HALF_2M048), int'(EBH_HALF_1M536), int'(EBH_HALF_4M096)};
    {reset_n, hsel, hwrite, htrans, haddr, hwdata, comp_dd, ext_dd, ext_on} = '0;
    hsize = 3'h2;
    do_reset();
    check("strap", 32'(tgt_mode_strap), 32'(EBH_MODE_RWS16));
    check("tgt_reset_n", 32'(tgt_reset_n), 32'h0);
    rdc("first", 32'(EBH_OFS_FIRST), 32'(EBH_RST_FIRST));
    rdc("second", 32'(EBH_OFS_SECOND), 32'(EBH_RST_SECOND));
    wr(32'(EBH_OFS_THIRD), 32'hdead_be02);
    rdc("third", 32'(EBH_OFS_THIRD), 32'h02);
    wr(32'h010, 32'h55);
    rdc("unmapped", 32'h010, 32'h0);
    // Every emulated style, two addresses each so address faults collide
    for (int m = 0; m < 6; m++) begin
      md = 4'(m);
      d = 16'hb700 | 16'(m);
      set_mode(md);
      check("strap", 32'(tgt_mode_strap), 32'(md));
      check("tgt_reset_n", 32'(tgt_reset_n), 32'h1);
      {n_wait, n_ale, n_stb} = '0;
      wr(32'h46a, 32'(d));
      ea = md[0] ? 8'h1a : 8'h35;
      check("wait", 32'(n_wait), 32'(1 + EBH_SETUP_CYC + EBH_STROBE_CYC + EBH_HOLD_CYC));
      check("ale", 32'(n_ale), 32'(m >= 4));
      check("wstrobe", 32'(n_stb), m >= 2 ? 32'h0 : 32'(EBH_STROBE_CYC));
      if (m < 4) check("addr", 32'(seen_addr), 32'(ea));
      wr(32'h5a4, 32'(~d));
      rdc("tdata", 32'h46a, md[0] ? {24'h0, d[7:0]} : {16'h0, d});
    end
    // Codes that must not reach the parallel port
    foreach (nf[i]) begin
      set_mode(nf[i]);
      n_cs = 0;
      wr(32'h46a, 32'h1234);
      rdc("blocked", 32'h46a, 32'h0);
      check("cs", 32'(n_cs), 32'h0);
    end
    settle();
    check("comp_held", 32'(comp_reset_n), 32'h0);
    check("clk_off", 32'(comp_pcm_clk), 32'h0);
    wr(32'(EBH_OFS_FIRST), 32'h3);
    for (int c = 0; c < 3; c++) begin
      wr(32'(EBH_OFS_THIRD), 32'(c));
      half(h);
      n_diff = 0;
      half(h);
      check("half", 32'(h), 32'(he[c]));
      check("clk_pair", 32'(n_diff), 32'h0);
    end
    frame_len(h);
    check("frame", 32'(h), 32'(int'(EBH_FRAME_4M096) * 2 * int'(EBH_HALF_4M096)));
    check("comp_run", 32'(comp_reset_n), 32'h1);
    check("dcl_oe", 32'(iom_dcl_oe), 32'h1);
    comp_dd <= 1'b1;
    settle();
    check("dd_comp", 32'(tgt_dd), 32'h1);
    ext_on <= 1'b1;
    wr(32'(EBH_OFS_FIRST), 32'h7);
    comp_dd <= 1'b0;
    ext_dd <= 1'b1;
    settle();
    check("ext_comp", 32'(comp_reset_n), 32'h0);
    check("ext_oe", 32'({iom_dcl_oe, iom_fsc_oe}), 32'h0);
    check("dd_ext", 32'(tgt_dd), 32'h1);
    // Second reset in mid-run restores the default style
    do_reset();
    check("strap", 32'(tgt_mode_strap), 32'(EBH_MODE_RWS16));
    rdc("first", 32'(EBH_OFS_FIRST), 32'h0);
    tally_and_finish();
  end
endmodule
